// file: cst_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// crypto engine stand-in: one op at a time, answer after a set delay
module cst_engine_model (
	input wire logic ref_clk,
	input wire cst_pkg::cst_eng_req_t eng_req,
	input wire cst_pkg::cst_op_t fail_op,
	input wire logic [3:0] lat,
	output cst_pkg::cst_eng_rsp_t eng_rsp
);
	logic [3:0] cnt_r = 4'h0; // cycles left before answering
	logic busy_r = 1'b0; // op outstanding
	logic pass_r = 1'b0; // verdict of the pending op
	logic junk_r = 1'b0; // pass is garbage outside done
	// launch on start, count down, one-cycle done
	always_ff @(posedge ref_clk) begin
		junk_r <= ~junk_r;
		eng_rsp.done <= 1'b0;
		eng_rsp.pass <= junk_r;
		if (eng_req.start === 1'b1) begin
			busy_r <= 1'b1;
			cnt_r <= lat;
			pass_r <= (eng_req.op !== fail_op);
		end else if (busy_r) begin
			if (cnt_r == 4'h0) begin
				busy_r <= 1'b0;
				eng_rsp.done <= 1'b1;
				eng_rsp.pass <= pass_r;
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule : cst_engine_model
`default_nettype wire

// file: cst_health.sv
`timescale 1ns/1ps
`default_nettype none
// repetition and adaptive proportion checks on raw bits
module cst_health #(
	parameter int RUN_CUT = cst_pkg::RUN_CUTOFF,
	parameter int PROP_CUT = cst_pkg::PROP_CUTOFF,
	parameter int PROP_WIN = cst_pkg::PROP_WINDOW
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic raw_valid,
	input wire logic raw_bit,
	output logic fail,
	output logic ready
);
	localparam int RW = $clog2(RUN_CUT + 1);
	localparam int AW = $clog2(PROP_WIN + 1);
	logic last_r; // previous raw bit
	logic [RW-1:0] run_cnt_r; // current run length
	logic prop_ref_r; // first bit of window
	logic [AW-1:0] prop_cnt_r; // matches in window
	logic [AW-1:0] prop_pos_r; // position in window
	logic fail_r; // sticky health failure
	logic ready_r; // first window complete
	logic run_hit; // run cutoff reached
	logic prop_hit; // proportion cutoff reached
	// run reaches cutoff on this bit
	assign run_hit = raw_valid && run_cnt_r != '0 && raw_bit == last_r
		&& run_cnt_r == RW'(RUN_CUT - 1);
	// window proportion reaches cutoff on this bit
	assign prop_hit = raw_valid && prop_pos_r != '0 && raw_bit == prop_ref_r
		&& prop_cnt_r == AW'(PROP_CUT - 1);
	// repetition run counter
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			last_r <= 1'b0;
			run_cnt_r <= '0;
		end else if (raw_valid) begin
			last_r <= raw_bit;
			if (run_cnt_r != '0 && raw_bit == last_r) begin
				run_cnt_r <= run_cnt_r + RW'(1);
			end else begin
				run_cnt_r <= RW'(1);
			end
		end
	end
	// proportion window counter
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			prop_ref_r <= 1'b0;
			prop_cnt_r <= '0;
			prop_pos_r <= '0;
		end else if (raw_valid) begin
			if (prop_pos_r == '0) begin
				prop_ref_r <= raw_bit;
				prop_cnt_r <= AW'(1);
				prop_pos_r <= AW'(1);
			end else begin
				if (raw_bit == prop_ref_r) begin
					prop_cnt_r <= prop_cnt_r + AW'(1);
				end
				prop_pos_r <= (prop_pos_r == AW'(PROP_WIN - 1)) ? '0 : prop_pos_r + AW'(1);
			end
		end
	end
	// sticky fail and first-window ready, checks never stop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fail_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			if (run_hit || prop_hit) begin
				fail_r <= 1'b1;
			end
			if (raw_valid && prop_pos_r == AW'(PROP_WIN - 1)) begin
				ready_r <= 1'b1;
			end
		end
	end
	assign fail = fail_r;
	assign ready = ready_r;
	// run of cutoff equal bits raises fail
	property p_run_fail;
		@(posedge ref_clk) disable iff (!resetn)
		run_hit |=> fail_r;
	endproperty
	a_run_fail: assert property (p_run_fail) else $error("run cutoff missed");
endmodule : cst_health
`default_nettype wire

// file: cst_pkg.sv
`default_nettype none
// shared constants and types for the self-test supervisor
package cst_pkg;
	// clock and periodic integrity interval
	localparam longint CLK_HZ = 10_000_000;
	localparam longint PERIODIC_MIN = 30; // minutes
	localparam longint PERIODIC_CYC = PERIODIC_MIN * 60 * CLK_HZ;
	localparam int TMR_W = 36;
	// raw source health limits
	localparam int RUN_CUTOFF = 40;
	localparam int PROP_CUTOFF = 684;
	localparam int PROP_WINDOW = 1024;
	// generate request limit, as a power of two
	localparam int GEN_LIMIT_LOG2 = 48;
	localparam int GEN_W = GEN_LIMIT_LOG2 + 1;
	// known-answer vector sizes in bits
	localparam logic [9:0] AES_KEY_BITS = 10'h080;
	localparam logic [10:0] CMAC_MSG_BITS = 11'h100;
	localparam logic [10:0] DRBG_ENT_BITS = 11'h378;
	localparam logic [9:0] DRBG_NONCE_BITS = 10'h080;
	localparam logic [10:0] DRBG_GEN_BITS = 11'h400;
	localparam logic [9:0] HMAC_KEY_BITS = 10'h200;
	localparam logic [10:0] HMAC_TEXT_BITS = 11'h110;
	// logged error codes
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_AES = 8'h01;
	localparam logic [7:0] ERR_DRBG = 8'h02;
	localparam logic [7:0] ERR_HMAC = 8'h03;
	localparam logic [7:0] ERR_INTEG = 8'h04;
	localparam logic [7:0] ERR_UNWRAP = 8'h05;
	localparam logic [7:0] ERR_KEY_LOAD = 8'h06;
	localparam logic [7:0] ERR_IV_LOAD = 8'h07;
	localparam logic [7:0] ERR_KEY_WRAP = 8'h08;
	localparam logic [7:0] ERR_ENCRYPT = 8'h09;
	localparam logic [7:0] ERR_ENTROPY = 8'h0a;
	localparam logic [7:0] ERR_SEED = 8'h0b;
	localparam logic [7:0] ERR_RESEED = 8'h0c;
	localparam logic [7:0] ERR_ENV = 8'h0d;
	localparam logic [7:0] ERR_FLASH = 8'h0e;
	// supervisor states
	typedef enum logic [3:0] {
		ST_INTEG = 4'b0000,
		ST_RNG_HEALTH = 4'b0001,
		ST_CMAC = 4'b0010,
		ST_AES_WRAP = 4'b0011,
		ST_AES_UNWRAP = 4'b0100,
		ST_DRBG_INST = 4'b0101,
		ST_DRBG_GEN = 4'b0110,
		ST_HMAC = 4'b0111,
		ST_OPER = 4'b1000,
		ST_PERIODIC = 4'b1001,
		ST_FWCHK = 4'b1010,
		ST_ERROR = 4'b1011
	} cst_state_t;
	// engine operations
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SHA_INTEG = 4'h1,
		OP_CMAC = 4'h2,
		OP_AES_WRAP = 4'h3,
		OP_AES_UNWRAP = 4'h4,
		OP_DRBG_INST = 4'h5,
		OP_DRBG_GEN = 4'h6,
		OP_HMAC = 4'h7,
		OP_FW_HMAC = 4'h8
	} cst_op_t;
	// command to the crypto engine
	typedef struct packed {
		logic start;
		logic wipe;
		cst_op_t op;
		logic [9:0] key_bits;
		logic [10:0] data_bits;
	} cst_eng_req_t;
	// engine answer
	typedef struct packed {
		logic done;
		logic pass;
	} cst_eng_rsp_t;
	// runtime faults reported by the datapath
	typedef struct packed {
		logic unwrap;
		logic key_load;
		logic iv_load;
		logic key_wrap;
		logic encrypt;
		logic entropy;
		logic seed;
		logic env;
		logic flash;
	} cst_fault_t;
	// host service request
	typedef struct packed {
		logic valid;
		logic crypto;
		logic gen;
		logic log_clear;
		logic auth;
	} cst_svc_req_t;
	// host service answer
	typedef struct packed {
		logic valid;
		logic ok;
		logic err;
		logic [7:0] log;
	} cst_svc_rsp_t;
endpackage : cst_pkg
`default_nettype wire

// file: cst_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module cst_supervisor #(
	parameter longint PERIOD_CYC = cst_pkg::PERIODIC_CYC,
	parameter int GEN_LOG2 = cst_pkg::GEN_LIMIT_LOG2
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic raw_valid,
	input wire logic raw_bit,
	input wire cst_pkg::cst_eng_rsp_t eng_rsp,
	output cst_pkg::cst_eng_req_t eng_req,
	input wire cst_pkg::cst_svc_req_t svc_req,
	output cst_pkg::cst_svc_rsp_t svc_rsp,
	output logic svc_ready,
	input wire cst_pkg::cst_fault_t fault,
	input wire logic fw_req,
	output logic fw_apply,
	output logic fw_reject,
	output logic [7:0] err_code,
	output logic in_error,
	output logic oper
);
	localparam int GW = GEN_LOG2 + 1; // generate counter width
	cst_pkg::cst_state_t st_r; // current state
	logic in_error_r; // registered error state flag
	logic oper_r; // registered service state flag
	cst_pkg::cst_state_t st_nxt; // next state
	logic [7:0] code_nxt; // code logged on error entry
	logic go_err; // error entry this cycle
	logic launched_r; // engine start issued
	logic gen_twice_r; // first generate done
	cst_pkg::cst_eng_req_t eng_req_r;
	cst_pkg::cst_svc_rsp_t svc_rsp_r;
	logic svc_ready_r;
	logic fw_apply_r;
	logic fw_reject_r;
	logic [7:0] err_code_r;
	logic [cst_pkg::TMR_W-1:0] tmr_r; // periodic timer
	logic per_pend_r; // periodic check due
	logic [GW-1:0] gen_cnt_r; // served generates
	logic gen_over; // count past limit
	logic hc_fail; // raw source health failure
	logic hc_ready; // first window passed
	logic svc_take; // request accepted
	logic eng_fin; // launched test finished
	// engine op for each test state
	function automatic cst_pkg::cst_op_t op_of(input cst_pkg::cst_state_t s);
		case (s)
			cst_pkg::ST_INTEG: op_of = cst_pkg::OP_SHA_INTEG;
			cst_pkg::ST_CMAC: op_of = cst_pkg::OP_CMAC;
			cst_pkg::ST_AES_WRAP: op_of = cst_pkg::OP_AES_WRAP;
			cst_pkg::ST_AES_UNWRAP: op_of = cst_pkg::OP_AES_UNWRAP;
			cst_pkg::ST_DRBG_INST: op_of = cst_pkg::OP_DRBG_INST;
			cst_pkg::ST_DRBG_GEN: op_of = cst_pkg::OP_DRBG_GEN;
			cst_pkg::ST_HMAC: op_of = cst_pkg::OP_HMAC;
			cst_pkg::ST_PERIODIC: op_of = cst_pkg::OP_SHA_INTEG;
			cst_pkg::ST_FWCHK: op_of = cst_pkg::OP_FW_HMAC;
			default: op_of = cst_pkg::OP_NONE;
		endcase
	endfunction : op_of
	// error code when a test state fails
	function automatic logic [7:0] code_of(input cst_pkg::cst_state_t s);
		case (s)
			cst_pkg::ST_INTEG: code_of = cst_pkg::ERR_INTEG;
			cst_pkg::ST_PERIODIC: code_of = cst_pkg::ERR_INTEG;
			cst_pkg::ST_CMAC: code_of = cst_pkg::ERR_ENTROPY;
			cst_pkg::ST_AES_WRAP: code_of = cst_pkg::ERR_AES;
			cst_pkg::ST_AES_UNWRAP: code_of = cst_pkg::ERR_AES;
			cst_pkg::ST_DRBG_INST: code_of = cst_pkg::ERR_DRBG;
			cst_pkg::ST_DRBG_GEN: code_of = cst_pkg::ERR_DRBG;
			cst_pkg::ST_HMAC: code_of = cst_pkg::ERR_HMAC;
			default: code_of = cst_pkg::ERR_NONE;
		endcase
	endfunction : code_of
	// runtime fault to code, lowest code first
	function automatic logic [7:0] fault_code(input cst_pkg::cst_fault_t f);
		if (f.unwrap) fault_code = cst_pkg::ERR_UNWRAP;
		else if (f.key_load) fault_code = cst_pkg::ERR_KEY_LOAD;
		else if (f.iv_load) fault_code = cst_pkg::ERR_IV_LOAD;
		else if (f.key_wrap) fault_code = cst_pkg::ERR_KEY_WRAP;
		else if (f.encrypt) fault_code = cst_pkg::ERR_ENCRYPT;
		else if (f.entropy) fault_code = cst_pkg::ERR_ENTROPY;
		else if (f.seed) fault_code = cst_pkg::ERR_SEED;
		else if (f.env) fault_code = cst_pkg::ERR_ENV;
		else fault_code = cst_pkg::ERR_FLASH;
	endfunction : fault_code
	// raw source health checks
	cst_health u_health (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.raw_valid(raw_valid),
		.raw_bit(raw_bit),
		.fail(hc_fail),
		.ready(hc_ready)
	);
	assign eng_fin = launched_r && eng_rsp.done;
	assign svc_take = svc_req.valid && svc_ready_r;
	assign gen_over = gen_cnt_r[GW-1] && (|gen_cnt_r[GW-2:0]);
	// next state and error code selection
	always_comb begin
		st_nxt = st_r;
		code_nxt = cst_pkg::ERR_NONE;
		go_err = 1'b0;
		if (st_r != cst_pkg::ST_ERROR) begin
			if (|fault) begin
				go_err = 1'b1;
				code_nxt = fault_code(fault);
			end else if (hc_fail) begin
				go_err = 1'b1;
				code_nxt = cst_pkg::ERR_ENTROPY;
			end else if (gen_over) begin
				go_err = 1'b1;
				code_nxt = cst_pkg::ERR_RESEED;
			end else begin
				case (st_r)
					// rng waits for a clean health window
					cst_pkg::ST_RNG_HEALTH: begin
						if (hc_ready) begin
							st_nxt = cst_pkg::ST_CMAC;
						end
					end
					// service, firmware check or periodic check
					cst_pkg::ST_OPER: begin
						if (fw_req) begin
							st_nxt = cst_pkg::ST_FWCHK;
						end else if (per_pend_r && !svc_req.valid) begin
							st_nxt = cst_pkg::ST_PERIODIC;
						end
					end
					// firmware image result never errors
					cst_pkg::ST_FWCHK: begin
						if (eng_fin) begin
							st_nxt = cst_pkg::ST_OPER;
						end
					end
					// every other state is a known-answer step
					default: begin
						if (eng_fin && !eng_rsp.pass) begin
							go_err = 1'b1;
							code_nxt = code_of(st_r);
						end else if (eng_fin) begin
							case (st_r)
								cst_pkg::ST_INTEG: st_nxt = cst_pkg::ST_RNG_HEALTH;
								cst_pkg::ST_CMAC: st_nxt = cst_pkg::ST_AES_WRAP;
								cst_pkg::ST_AES_WRAP: st_nxt = cst_pkg::ST_AES_UNWRAP;
								cst_pkg::ST_AES_UNWRAP: st_nxt = cst_pkg::ST_DRBG_INST;
								cst_pkg::ST_DRBG_INST: st_nxt = cst_pkg::ST_DRBG_GEN;
								cst_pkg::ST_DRBG_GEN: begin
									st_nxt = gen_twice_r ? cst_pkg::ST_HMAC
										: cst_pkg::ST_DRBG_GEN;
								end
								default: st_nxt = cst_pkg::ST_OPER;
							endcase
						end
					end
				endcase
			end
			if (go_err) begin
				st_nxt = cst_pkg::ST_ERROR;
			end
		end
	end
	// state register, restart from integrity on reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= cst_pkg::ST_INTEG;
			in_error_r <= 1'b0;
			oper_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			in_error_r <= st_nxt == cst_pkg::ST_ERROR;
			oper_r <= st_nxt == cst_pkg::ST_OPER;
		end
	end
	// engine launch, vector sizes and wipe
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			eng_req_r <= '0;
			launched_r <= 1'b0;
			gen_twice_r <= 1'b0;
		end else begin
			eng_req_r.start <= 1'b0;
			eng_req_r.wipe <= 1'b0;
			if (eng_fin) begin
				launched_r <= 1'b0;
				eng_req_r.wipe <= 1'b1;
				if (st_r == cst_pkg::ST_DRBG_GEN) begin
					gen_twice_r <= 1'b1;
				end
			end else if (!launched_r && op_of(st_r) != cst_pkg::OP_NONE && !go_err) begin
				launched_r <= 1'b1;
				eng_req_r.start <= 1'b1;
				eng_req_r.op <= op_of(st_r);
				eng_req_r.key_bits <= '0;
				eng_req_r.data_bits <= '0;
				case (st_r)
					cst_pkg::ST_CMAC: begin
						eng_req_r.key_bits <= cst_pkg::AES_KEY_BITS;
						eng_req_r.data_bits <= cst_pkg::CMAC_MSG_BITS;
					end
					cst_pkg::ST_AES_WRAP, cst_pkg::ST_AES_UNWRAP: begin
						eng_req_r.key_bits <= cst_pkg::AES_KEY_BITS;
					end
					cst_pkg::ST_DRBG_INST: begin
						eng_req_r.key_bits <= cst_pkg::DRBG_NONCE_BITS;
						eng_req_r.data_bits <= cst_pkg::DRBG_ENT_BITS;
					end
					cst_pkg::ST_DRBG_GEN: begin
						eng_req_r.data_bits <= cst_pkg::DRBG_GEN_BITS;
					end
					cst_pkg::ST_HMAC, cst_pkg::ST_FWCHK: begin
						eng_req_r.key_bits <= cst_pkg::HMAC_KEY_BITS;
						eng_req_r.data_bits <= cst_pkg::HMAC_TEXT_BITS;
					end
					default: begin
						eng_req_r.key_bits <= '0;
					end
				endcase
			end
		end
	end
	// firmware image accept or refuse
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			fw_apply_r <= 1'b0;
			fw_reject_r <= 1'b0;
		end else begin
			fw_apply_r <= st_r == cst_pkg::ST_FWCHK && eng_fin && eng_rsp.pass;
			fw_reject_r <= st_r == cst_pkg::ST_FWCHK && eng_fin && !eng_rsp.pass;
		end
	end
	// periodic integrity timer, runs only in service state
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tmr_r <= '0;
			per_pend_r <= 1'b0;
		end else if (st_r == cst_pkg::ST_PERIODIC) begin
			per_pend_r <= 1'b0;
			tmr_r <= '0;
		end else if (st_r == cst_pkg::ST_OPER && !per_pend_r) begin
			if (tmr_r == cst_pkg::TMR_W'(PERIOD_CYC - 1)) begin
				per_pend_r <= 1'b1;
				tmr_r <= '0;
			end else begin
				tmr_r <= tmr_r + cst_pkg::TMR_W'(1);
			end
		end
	end
	// generate request counter
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gen_cnt_r <= '0;
		end else if (svc_take && svc_req.gen && st_r == cst_pkg::ST_OPER && !gen_over) begin
			gen_cnt_r <= gen_cnt_r + GW'(1);
		end
	end
	// error log, entry wins over clear
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			err_code_r <= cst_pkg::ERR_NONE;
		end else if (go_err) begin
			err_code_r <= code_nxt;
		end else if (svc_take && svc_req.log_clear && svc_req.auth) begin
			err_code_r <= cst_pkg::ERR_NONE;
		end
	end
	// service answers, crypto refused in error
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			svc_rsp_r <= '0;
			svc_ready_r <= 1'b0;
		end else begin
			svc_ready_r <= st_nxt == cst_pkg::ST_OPER || st_nxt == cst_pkg::ST_ERROR;
			svc_rsp_r.valid <= svc_take;
			svc_rsp_r.log <= err_code_r;
			if (st_r == cst_pkg::ST_ERROR && svc_req.crypto) begin
				svc_rsp_r.ok <= 1'b0;
				svc_rsp_r.err <= svc_take;
			end else if (svc_req.log_clear && !svc_req.auth) begin
				svc_rsp_r.ok <= 1'b0;
				svc_rsp_r.err <= svc_take;
			end else begin
				svc_rsp_r.ok <= svc_take;
				svc_rsp_r.err <= 1'b0;
			end
		end
	end
	assign eng_req = eng_req_r;
	assign svc_rsp = svc_rsp_r;
	assign svc_ready = svc_ready_r;
	assign fw_apply = fw_apply_r;
	assign fw_reject = fw_reject_r;
	assign err_code = err_code_r;
	assign in_error = in_error_r;
	assign oper = oper_r;
	// a finished test is followed by a wipe
	sequence s_test_done;
		eng_fin && st_r != cst_pkg::ST_FWCHK;
	endsequence
	sequence s_wipe;
		eng_req_r.wipe && !eng_req_r.start;
	endsequence
	property p_wipe;
		@(posedge ref_clk) disable iff (!resetn)
		s_test_done |=> s_wipe;
	endproperty
	a_wipe: assert property (p_wipe) else $error("no wipe after test");
	property p_err_stays;
		@(posedge ref_clk) disable iff (!resetn)
		st_r == cst_pkg::ST_ERROR |=> st_r == cst_pkg::ST_ERROR && !oper;
	endproperty
	a_err_stays: assert property (p_err_stays) else $error("left error state");
	property p_crypto_refused;
		@(posedge ref_clk) disable iff (!resetn)
		svc_take && svc_req.crypto && in_error |=> svc_rsp_r.err && !svc_rsp_r.ok;
	endproperty
	a_crypto_refused: assert property (p_crypto_refused) else $error("crypto served");
	property p_code_logged;
		@(posedge ref_clk) disable iff (!resetn)
		st_r != cst_pkg::ST_ERROR && st_nxt == cst_pkg::ST_ERROR
			|=> err_code_r == $past(code_nxt) && err_code_r != cst_pkg::ERR_NONE;
	endproperty
	a_code_logged: assert property (p_code_logged) else $error("bad code");
	property p_aes_code;
		@(posedge ref_clk) disable iff (!resetn)
		st_r == cst_pkg::ST_AES_WRAP && eng_fin && !eng_rsp.pass && !(|fault) && !hc_fail
			|=> in_error && err_code_r == cst_pkg::ERR_AES;
	endproperty
	a_aes_code: assert property (p_aes_code) else $error("aes code wrong");
	property p_fw_refuse;
		@(posedge ref_clk) disable iff (!resetn)
		st_r == cst_pkg::ST_FWCHK && eng_fin && !eng_rsp.pass |=> fw_reject_r && !fw_apply_r;
	endproperty
	a_fw_refuse: assert property (p_fw_refuse) else $error("bad image applied");
	property p_health_err;
		@(posedge ref_clk) disable iff (!resetn)
		hc_fail && !(|fault) && !in_error |=> in_error ##0 err_code_r == cst_pkg::ERR_ENTROPY;
	endproperty
	a_health_err: assert property (p_health_err) else $error("health miss");
	property p_gen_limit;
		@(posedge ref_clk) disable iff (!resetn)
		gen_over |=> in_error;
	endproperty
	a_gen_limit: assert property (p_gen_limit) else $error("generate limit");
	property p_start_integ;
		@(posedge ref_clk) disable iff (!resetn)
		$rose(launched_r) && $past(st_r) == cst_pkg::ST_INTEG
			|-> eng_req_r.start && eng_req_r.op == cst_pkg::OP_SHA_INTEG;
	endproperty
	a_start_integ: assert property (p_start_integ) else $error("integrity not run");
endmodule : cst_supervisor
`default_nettype wire

// file: cst_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the self-test supervisor
module cst_supervisor_bench;
	localparam longint PER = 600; // shortened periodic interval
	localparam int GLOG = 2; // shortened generate limit, 2^2
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic raw_valid = 1'b0;
	logic raw_bit = 1'b0;
	logic stuck = 1'b0; // forces a constant raw stream
	cst_pkg::cst_eng_rsp_t eng_rsp;
	cst_pkg::cst_eng_req_t eng_req;
	cst_pkg::cst_svc_req_t svc_req = '0;
	cst_pkg::cst_svc_rsp_t svc_rsp;
	cst_pkg::cst_fault_t fault = '0;
	cst_pkg::cst_op_t fail_op = cst_pkg::OP_NONE;
	cst_pkg::cst_op_t fops[5] = '{cst_pkg::OP_AES_WRAP, cst_pkg::OP_DRBG_GEN,
		cst_pkg::OP_HMAC, cst_pkg::OP_SHA_INTEG, cst_pkg::OP_CMAC};
	logic [7:0] codes[15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h0a, 8'h05, 8'h06, 8'h07,
		8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h0a};
	logic svc_ready;
	logic fw_req = 1'b0;
	logic fw_apply;
	logic fw_reject;
	logic [7:0] err_code;
	logic in_error;
	logic oper;
	logic [3:0] lat = 4'h0; // engine answer delay
	logic [31:0] seed = 32'h0000001c; // xorshift state
	logic [24:0] op_q[$]; // expected {op,key,data} per start
	logic [10:0] rsp_q[$]; // expected service answers
	logic [24:0] e_op;
	logic boot_done = 1'b0; // periodic checks tolerated
	logic done_d = 1'b0;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	// clock, 100 ns period
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	cst_supervisor #(.PERIOD_CYC(PER), .GEN_LOG2(GLOG)) uut (.ref_clk(ref_clk), .resetn(resetn),
		.raw_valid(raw_valid), .raw_bit(raw_bit), .eng_rsp(eng_rsp), .eng_req(eng_req),
		.svc_req(svc_req), .svc_rsp(svc_rsp), .svc_ready(svc_ready), .fault(fault),
		.fw_req(fw_req), .fw_apply(fw_apply), .fw_reject(fw_reject),
		.err_code(err_code), .in_error(in_error), .oper(oper));
	cst_engine_model eng (.ref_clk(ref_clk), .eng_req(eng_req), .fail_op(fail_op),
		.lat(lat), .eng_rsp(eng_rsp));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// compare and count
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk
	task automatic test_done();
		$display("counts: run=%0d bad=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic rst();
		resetn <= 1'b0;
		repeat (20) @(posedge ref_clk);
		resetn <= 1'b1;
	endtask : rst
	// one service request, held until taken
	task automatic svc(input logic [4:0] rq, input logic [10:0] exp);
		svc_req <= rq;
		@(posedge ref_clk);
		repeat (3000) if (svc_ready !== 1'b1) @(posedge ref_clk);
		rsp_q.push_back(exp);
		svc_req <= '0;
		@(posedge ref_clk);
	endtask : svc
	// firmware image check, good or bad
	task automatic fw(input logic good);
		op_q.push_back({cst_pkg::OP_FW_HMAC, 10'h200, 11'h110});
		fail_op <= good ? cst_pkg::OP_NONE : cst_pkg::OP_FW_HMAC;
		fw_req <= 1'b1;
		@(posedge ref_clk);
		repeat (3000) if (oper === 1'b1) @(posedge ref_clk);
		fw_req <= 1'b0;
		repeat (100) if (fw_apply !== 1'b1 && fw_reject !== 1'b1) @(posedge ref_clk);
		chk({good, !good}, {fw_apply, fw_reject});
		chk(0, in_error);
		@(posedge ref_clk);
	endtask : fw
	// raw bits every cycle, random engine delay, timeout
	always @(posedge ref_clk) begin
		seed <= xs(seed);
		raw_valid <= 1'b1;
		raw_bit <= stuck ? 1'b1 : seed[0];
		lat <= {seed[7], 1'b0, seed[5:4]};
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			test_done();
		end
	end
	// watcher: engine launches, wipes, service answers
	always @(posedge ref_clk) begin
		done_d <= (eng_rsp.done === 1'b1) && (resetn === 1'b1);
		if (done_d && resetn === 1'b1) chk(1, eng_req.wipe);
		if (eng_req.start === 1'b1 && op_q.size() > 0
			&& !(boot_done && eng_req.op === cst_pkg::OP_SHA_INTEG)) begin
			e_op = op_q.pop_front();
			chk(e_op[24:21], eng_req.op);
			if (e_op[20:11] != 10'h3ff) chk(e_op[20:11], eng_req.key_bits);
			if (e_op[10:0] != 11'h7ff) chk(e_op[10:0], eng_req.data_bits);
		end
		if (svc_rsp.valid === 1'b1) begin
			if (rsp_q.size() == 0) chk(0, 1);
			else chk(rsp_q.pop_front(), svc_rsp);
		end
	end
	// main sequence
	initial begin
		op_q.push_back({cst_pkg::OP_SHA_INTEG, 10'h000, 11'h000});
		op_q.push_back({cst_pkg::OP_CMAC, 10'h080, 11'h100});
		op_q.push_back({cst_pkg::OP_AES_WRAP, 10'h080, 11'h7ff});
		op_q.push_back({cst_pkg::OP_AES_UNWRAP, 10'h080, 11'h7ff});
		op_q.push_back({cst_pkg::OP_DRBG_INST, 10'h080, 11'h378});
		op_q.push_back({cst_pkg::OP_DRBG_GEN, 10'h3ff, 11'h400});
		op_q.push_back({cst_pkg::OP_DRBG_GEN, 10'h3ff, 11'h400});
		op_q.push_back({cst_pkg::OP_HMAC, 10'h200, 11'h110});
		rst();
		repeat (5000) if (oper !== 1'b1) @(posedge ref_clk);
		chk(1, svc_ready);
		chk(0, op_q.size());
		chk(8'h00, err_code);
		boot_done = 1'b1;
		$display("boot sequence finished");
		svc(5'b11100, {3'b110, 8'h00});
		svc(5'b10010, {3'b101, 8'h00});
		fw(1'b1);
		fw(1'b0);
		$display("service and firmware finished");
		repeat (PER + 100) if (!(eng_req.start === 1'b1
			&& eng_req.op === cst_pkg::OP_SHA_INTEG)) @(posedge ref_clk);
		chk(1, eng_req.start);
		$display("periodic check finished");
		// one generate already served; four more pass the 2^GLOG limit
		for (int k = 0; k < 4; k++) begin
			svc(5'b10100, {3'b110, 8'h00});
		end
		repeat (20) if (in_error !== 1'b1) @(posedge ref_clk);
		chk(8'h0c, err_code);
		chk(1, in_error);
		$display("generate limit finished");
		// five failing tests, every fault and a health trip
		for (int i = 0; i < 15; i++) begin
			fail_op <= (i < 5) ? fops[i] : cst_pkg::OP_NONE;
			rst();
			repeat (5000) if (oper !== 1'b1 && in_error !== 1'b1) @(posedge ref_clk);
			if (i == 14) stuck = 1'b1;
			else if (i >= 5) fault <= 9'h100 >> (i - 5);
			repeat (3000) if (in_error !== 1'b1) @(posedge ref_clk);
			chk(codes[i], err_code);
			chk(0, oper);
			fault <= '0;
			stuck = 1'b0;
		end
		$display("error codes finished");
		svc(5'b11000, {3'b101, 8'h0a});
		svc(5'b10011, {3'b110, 8'h0a});
		repeat (3) @(posedge ref_clk);
		chk(8'h00, err_code);
		chk(1, in_error);
		chk(0, rsp_q.size());
		$display("error state finished");
		test_done();
	end
endmodule : cst_supervisor_bench
`default_nettype wire
